// ---- rtl/wcm_consts.svh ----
// Offsets, field positions, reset values and timing counts of the watchdog and clock monitor
`ifndef WCM_CONSTS_SVH
`define WCM_CONSTS_SVH
`define WCM_IDX_OPTION 16'h1039
`define WCM_IDX_SERVICE 16'h103a
`define WCM_IDX_STATUS 16'h103b
`define WCM_IDX_TEST 16'h103e
`define WCM_IDX_CONFIG 16'h103f
`define WCM_OPTION_RST 8'h10
`define WCM_CONFIG_ONES 8'h0a
`define WCM_CFG_WATCHDOG_DISABLE 2
`define WCM_TEST_DISABLE_RESETS_BIT 0
`define WCM_ARM_CODE 8'h55
`define WCM_CLEAR_CODE 8'haa
`define WCM_WRONCE_CYC 64
`define WCM_STOP_DLY_CYC 4000
`define WCM_STOP_FAST_CYC 4
`define WCM_RSTDRV_CYC 4
`define WCM_RSTSMP_CYC 2
`define WCM_PRESCALE_LOG2 15
`define WCM_MON_WIN_NS 20000
`define WCM_MON_OSC_KHZ 1000
`define WCM_VEC_EXT_NORM 16'hfffe
`define WCM_VEC_EXT_SPEC 16'hbffe
`define WCM_VEC_MON_NORM 16'hfffc
`define WCM_VEC_MON_SPEC 16'hbffc
`define WCM_VEC_WD_NORM 16'hfffa
`define WCM_VEC_WD_SPEC 16'hbffa
`endif

// ---- rtl/wcm_pkg.sv ----
// Types shared by the watchdog and clock monitor block
package wcm_pkg;
	typedef struct packed {
		logic adc_power;
		logic adc_clk_sel;
		logic irq_edge_select;
		logic stop_startup_delay;
		logic clock_monitor_enable;
		logic force_clock_monitor;
		logic [1:0] watchdog_rate_select;
	} wcm_option_t;
	typedef enum logic [1:0] {
		WCM_SEQ_IDLE = 2'b00,
		WCM_SEQ_DRIVE = 2'b01,
		WCM_SEQ_SAMPLE = 2'b10
	} wcm_seq_t;
	typedef enum logic [1:0] {
		WCM_CAUSE_EXT = 2'b00,
		WCM_CAUSE_MON = 2'b01,
		WCM_CAUSE_WD = 2'b10
	} wcm_cause_t;
endpackage

// ---- rtl/wcm_top.sv ----
// Watchdog, clock monitor, option/config registers and reset sequencer
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "wcm_consts.svh"

module wcm_top import wcm_pkg::*; #(
	parameter int PRESCALE_LOG2 = `WCM_PRESCALE_LOG2,
	parameter int MON_OSC_KHZ = `WCM_MON_OSC_KHZ
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Mode and latch straps
	input wire logic special_mode,
	input wire logic watchdog_disable_latch,
	// Stop mode
	input wire logic stop_mode,
	output logic cpu_run,
	// Interrupt request pin
	input wire logic irq_pin_n,
	input wire logic irq_ack,
	output logic irq_request,
	// Open-drain reset pin
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// System reset and vector
	output logic sys_reset,
	output logic [15:0] reset_vector,
	output logic vector_valid,
	// Monitor oscillator and its direct failure line
	input wire logic mon_osc,
	output logic clock_fail
);
	localparam int WDW = PRESCALE_LOG2 + 7;
	localparam int MON_WIN = (`WCM_MON_WIN_NS * MON_OSC_KHZ) / 1000000;
	localparam int MWW = $clog2(MON_WIN + 1);

	wcm_option_t option;
	logic [7:0] config_store;
	logic watchdog_disable_active;
	logic disable_resets_bit;
	logic special;
	logic init_pend;
	logic once_done;
	logic [6:0] win_cnt;
	logic armed;
	logic [WDW-1:0] wd_cnt;
	logic [WDW-1:0] wd_lim;
	logic wd_timeout;
	logic soft_rst;
	wcm_seq_t seq;
	wcm_cause_t cause;
	logic [2:0] seq_cnt;
	logic bus_tog;
	logic echo_s1;
	logic mon_tog;
	logic fail_s1;
	logic fail_s2;
	logic mon_en;
	logic en_s1;
	logic en_s2;
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic [MWW-1:0] mon_cnt;
	logic stop_d;
	logic [11:0] wake_cnt;
	logic irq_d;
	logic setup;
	logic wr;
	logic hit_opt;
	logic hit_svc;
	logic hit_sts;
	logic hit_tst;
	logic hit_cfg;
	logic [7:0] wbyte;
	logic wr_open;

	// Address decode, zero-wait answer, error on unmapped words
	assign hit_opt = paddr == {`WCM_IDX_OPTION, 2'b00};
	assign hit_svc = paddr == {`WCM_IDX_SERVICE, 2'b00};
	assign hit_sts = paddr == {`WCM_IDX_STATUS, 2'b00};
	assign hit_tst = paddr == {`WCM_IDX_TEST, 2'b00};
	assign hit_cfg = paddr == {`WCM_IDX_CONFIG, 2'b00};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(hit_opt | hit_svc | hit_sts | hit_tst | hit_cfg);
	assign setup = psel & ~penable & pclk_en;
	assign wr = psel & penable & pwrite & pclk_en & ~pslverr;
	assign wbyte = pwdata[7:0];
	assign soft_rst = pclk_en && seq == WCM_SEQ_SAMPLE && seq_cnt == 3'd0;

	// Read data registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup) begin
			prdata <= 32'h0;
			if (hit_opt)
				prdata[7:0] <= option;
			else if (hit_cfg)
				prdata[7:0] <= config_store | `WCM_CONFIG_ONES;
			else if (hit_tst)
				prdata[`WCM_TEST_DISABLE_RESETS_BIT] <= disable_resets_bit;
			else if (hit_sts)
				prdata[7:0] <= {armed, mon_en, watchdog_disable_active, special, cause, cpu_run, once_done};
		end
	end

	// Straps caught on the first cycle after any reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_pend <= 1'b1;
			special <= 1'b0;
			watchdog_disable_active <= 1'b1;
		end else if (pclk_en) begin
			if (soft_rst) begin
				init_pend <= 1'b1;
			end else if (init_pend) begin
				init_pend <= 1'b0;
				special <= special_mode;
				watchdog_disable_active <= config_store[`WCM_CFG_WATCHDOG_DISABLE];
			end
		end
	end

	// Config register; disable bit reloads its own stored value at each sequencer reset, not the latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_store <= 8'hff;
		end else if (pclk_en) begin
			if (init_pend && !soft_rst && seq == WCM_SEQ_IDLE)
				config_store[`WCM_CFG_WATCHDOG_DISABLE] <= config_store[`WCM_CFG_WATCHDOG_DISABLE];
			if (wr && hit_cfg)
				config_store <= wbyte;
		end
	end

	// Power-on done flag; the latch value never enters the config register
	logic strap_done;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			strap_done <= 1'b0;
		else
			strap_done <= 1'b1;
	end

	// Disable-resets bit starts set in special modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disable_resets_bit <= 1'b0;
		end else if (pclk_en) begin
			if (init_pend && !soft_rst)
				disable_resets_bit <= special_mode;
			else if (wr && hit_tst)
				disable_resets_bit <= wbyte[`WCM_TEST_DISABLE_RESETS_BIT];
		end
	end

	// Write-once window of 64 cycles after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt <= 7'd0;
			once_done <= 1'b0;
		end else if (pclk_en) begin
			if (soft_rst) begin
				win_cnt <= 7'd0;
				once_done <= 1'b0;
			end else begin
				if (win_cnt != 7'(`WCM_WRONCE_CYC))
					win_cnt <= win_cnt + 7'd1;
				if (wr && hit_opt && !special)
					once_done <= 1'b1;
			end
		end
	end
	assign wr_open = special || (win_cnt != 7'(`WCM_WRONCE_CYC) && !once_done);

	// Option register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option <= `WCM_OPTION_RST;
		end else if (pclk_en) begin
			if (soft_rst) begin
				option <= `WCM_OPTION_RST;
			end else if (wr && hit_opt) begin
				option.adc_power <= wbyte[7];
				option.adc_clk_sel <= wbyte[6];
				option.clock_monitor_enable <= wbyte[3];
				if (wr_open) begin
					option.irq_edge_select <= wbyte[5];
					option.stop_startup_delay <= wbyte[4];
					option.force_clock_monitor <= wbyte[2];
					option.watchdog_rate_select <= wbyte[1:0];
				end
			end
		end
	end

	// Service sequence: arm on 0x55, clear on armed 0xaa
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= 1'b0;
		end else if (pclk_en) begin
			if (soft_rst)
				armed <= 1'b0;
			else if (wr && hit_svc && wbyte == `WCM_ARM_CODE)
				armed <= 1'b1;
			else if (wr && hit_svc && wbyte == `WCM_CLEAR_CODE)
				armed <= 1'b0;
		end
	end

	// Watchdog counter, frozen while stopped
	assign wd_lim = WDW'((WDW'(1) << (PRESCALE_LOG2 + 2 * int'(option.watchdog_rate_select))) - WDW'(1));
	assign wd_timeout = seq == WCM_SEQ_IDLE && wd_cnt == wd_lim && !watchdog_disable_active && !disable_resets_bit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_cnt <= '0;
		end else if (pclk_en) begin
			if (seq != WCM_SEQ_IDLE || (wr && hit_svc && wbyte == `WCM_CLEAR_CODE && armed))
				wd_cnt <= '0;
			else if (!stop_mode && wd_cnt != wd_lim)
				wd_cnt <= wd_cnt + WDW'(1);
		end
	end

	// Reset sequencer: drive pin, wait, sample, choose vector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq <= WCM_SEQ_DRIVE;
			seq_cnt <= 3'(`WCM_RSTDRV_CYC - 1);
			cause <= WCM_CAUSE_EXT;
			reset_vector <= 16'h0;
			vector_valid <= 1'b0;
		end else if (pclk_en) begin
			vector_valid <= 1'b0;
			case (seq)
				WCM_SEQ_IDLE: begin
					if (!reset_pin_in || fail_s2 || wd_timeout) begin
						seq <= WCM_SEQ_DRIVE;
						seq_cnt <= 3'(`WCM_RSTDRV_CYC - 1);
						cause <= !reset_pin_in ? WCM_CAUSE_EXT : fail_s2 ? WCM_CAUSE_MON : WCM_CAUSE_WD;
					end
				end
				WCM_SEQ_DRIVE: begin
					seq_cnt <= seq_cnt - 3'd1;
					if (seq_cnt == 3'd0) begin
						seq <= WCM_SEQ_SAMPLE;
						seq_cnt <= 3'(`WCM_RSTSMP_CYC - 1);
					end
				end
				WCM_SEQ_SAMPLE: begin
					seq_cnt <= seq_cnt - 3'd1;
					if (seq_cnt == 3'd0) begin
						seq <= WCM_SEQ_IDLE;
						vector_valid <= 1'b1;
						if (!reset_pin_in || cause == WCM_CAUSE_EXT) begin
							cause <= WCM_CAUSE_EXT;
							reset_vector <= special_mode ? `WCM_VEC_EXT_SPEC : `WCM_VEC_EXT_NORM;
						end else if (cause == WCM_CAUSE_MON)
							reset_vector <= special_mode ? `WCM_VEC_MON_SPEC : `WCM_VEC_MON_NORM;
						else
							reset_vector <= special_mode ? `WCM_VEC_WD_SPEC : `WCM_VEC_WD_NORM;
					end
				end
				default: seq <= WCM_SEQ_IDLE;
			endcase
		end
	end
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = seq == WCM_SEQ_DRIVE;
	assign sys_reset = seq != WCM_SEQ_IDLE;

	// Bus clock echoes the monitor toggle; a plain divider could alias with the oscillator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			echo_s1 <= 1'b0;
			bus_tog <= 1'b0;
			fail_s1 <= 1'b0;
			fail_s2 <= 1'b0;
		end else if (pclk_en) begin
			echo_s1 <= mon_tog;
			bus_tog <= echo_s1;
			fail_s1 <= clock_fail;
			fail_s2 <= fail_s1;
		end
	end
	assign mon_en = option.clock_monitor_enable | option.force_clock_monitor;

	// Monitor timer on its own oscillator; window sits between 5 us and 100 us
	always_ff @(posedge mon_osc or negedge presetn) begin
		if (!presetn) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			mon_tog <= 1'b0;
			mon_cnt <= '0;
			clock_fail <= 1'b0;
		end else begin
			mon_tog <= ~mon_tog;
			en_s1 <= mon_en;
			en_s2 <= en_s1;
			tog_s1 <= bus_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			if (!en_s2) begin
				mon_cnt <= '0;
				clock_fail <= 1'b0;
			end else if (tog_s3 != tog_s2) begin
				mon_cnt <= '0;
			end else if (mon_cnt == MWW'(MON_WIN - 1)) begin
				clock_fail <= 1'b1;
			end else begin
				mon_cnt <= mon_cnt + MWW'(1);
			end
		end
	end

	// Stop wake-up delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_d <= 1'b0;
			wake_cnt <= 12'd0;
		end else if (pclk_en) begin
			stop_d <= stop_mode;
			if (stop_d && !stop_mode)
				wake_cnt <= option.stop_startup_delay ? 12'(`WCM_STOP_DLY_CYC) : 12'(`WCM_STOP_FAST_CYC);
			else if (wake_cnt != 12'd0)
				wake_cnt <= wake_cnt - 12'd1;
		end
	end
	assign cpu_run = !stop_mode && !stop_d && wake_cnt == 12'd0;

	// IRQ sensing: level or latched falling edge, edge wins over acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_d <= 1'b1;
			irq_request <= 1'b0;
		end else if (pclk_en) begin
			irq_d <= irq_pin_n;
			if (!option.irq_edge_select)
				irq_request <= !irq_pin_n;
			else if (irq_d && !irq_pin_n)
				irq_request <= 1'b1;
			else if (irq_ack)
				irq_request <= 1'b0;
		end
	end
endmodule

// ---- verification/wcm_checker.sv ----
// Checker for reset sequencing, vectors and bus errors of the watchdog block
`timescale 1ns/1ps
module wcm_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus request
	input wire logic psel,
	input wire logic penable,
	input wire logic [17:0] paddr,
	input wire logic pslverr,
	// Mode, stop and reset pin
	input wire logic special_mode,
	input wire logic stop_mode,
	input wire logic cpu_run,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic sys_reset,
	input wire logic [15:0] reset_vector,
	input wire logic vector_valid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Address decode of the five mapped registers
	logic ok;
	assign ok = paddr[1:0] == 2'b00 && paddr[17:2] inside {16'h1039, 16'h103a, 16'h103b, 16'h103e, 16'h103f};
	a_pin_drive: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*4] ##1 !reset_pin_oe)
		else $error("pin drive length wrong");
	a_pin_sample: assert property ($fell(reset_pin_oe) |-> !vector_valid ##[1:2] vector_valid)
		else $error("vector not after sample");
	a_pin_open: assert property (reset_pin_oe |-> sys_reset && !reset_pin_out)
		else $error("pin driven outside reset");
	a_vec_pulse: assert property (vector_valid |=> !vector_valid)
		else $error("vector strobe too long");
	a_vec_mode: assert property (vector_valid |-> reset_vector[15:14] == (special_mode ? 2'b10 : 2'b11))
		else $error("vector page wrong");
	a_ext_cause: assert property (vector_valid && !$past(reset_pin_in) |-> reset_vector[3:0] == 4'he)
		else $error("pin reset vector wrong");
	a_bus_err: assert property (pslverr == (psel && penable && !ok))
		else $error("slave error wrong");
	a_stop_run: assert property (stop_mode |-> !cpu_run)
		else $error("running in stop");
	c_wd: cover property (vector_valid && reset_vector[3:0] == 4'ha);
	c_mon: cover property (vector_valid && reset_vector[3:0] == 4'hc);
	c_err: cover property (pslverr);
endmodule
bind wcm_top wcm_checker i_wcm_checker (.*);

// ---- verification/wcm_cpu_model.sv ----
// Processor core model: register bus master and watchdog servicing
`timescale 1ns/1ps
module wcm_cpu_model (
	// Clock
	input wire logic pclk,
	// Register bus
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [17:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// One transfer: setup, access held until ready, then release
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'($urandom), d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~pwdata;
	endtask
	// Arm then clear, as software services the watchdog
	task automatic service();
		logic [7:0] q;
		logic e;
		xfer(1'b1, 16'h103a, 8'h55, q, e);
		xfer(1'b1, 16'h103a, 8'haa, q, e);
	endtask
endmodule

// ---- verification/watchdog_and_clock_monitor_tb.sv ----
// Self-checking bench for the watchdog and clock monitor block
`timescale 1ns/1ps
module watchdog_and_clock_monitor_tb;
	logic pclk = 0, presetn = 0, pclk_en = 1, special_mode = 0, stop_mode = 0, watchdog_disable_latch = 0;
	logic irq_pin_n = 1, irq_ack = 0, ext_low = 0, mon_osc = 0;
	logic psel, penable, pwrite, pready, pslverr, cpu_run, irq_request;
	logic reset_pin_out, reset_pin_oe, sys_reset, vector_valid, clock_fail, e;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] reset_vector;
	logic [7:0] q;
	logic [7:0] mv [3] = '{8'h10, 8'h18, 8'h14};
	int failures = 0, compares = 0, vcnt = 0, cyc;
	// Open-drain reset pin with pull-up
	wire reset_pin_in = !reset_pin_oe && !ext_low;
	always #12.5 pclk = !pclk;
	always #500 mon_osc = !mon_osc;
	always @(posedge pclk) if (vector_valid === 1'b1) vcnt++;
	wcm_top #(.PRESCALE_LOG2(4)) i_wcm_top (.*);
	wcm_cpu_model i_wcm_cpu_model (.*);
	// Option model: protected bits keep old value once locked
	function automatic int opt_next(int old, int w, bit lock);
		return lock ? (old & 'h37) | (w & 'hc8) : w;
	endfunction
	task automatic cmp_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cmp_cnt(input string nm, input int exp, input int tol, input int got);
		compares++;
		if (got < exp - tol || got > exp + tol) begin
			failures++;
			$display("wrong value %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		i_wcm_cpu_model.xfer(1'b1, idx, d, q, e);
	endtask
	task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
		i_wcm_cpu_model.xfer(1'b0, idx, 8'h00, q, e);
		cmp_val("register", {8'h00, exp}, {8'h00, q});
	endtask
	task automatic wait_vv(input int lim);
		cyc = 0;
		do begin
			@(posedge pclk);
			cyc++;
		end while (vector_valid !== 1'b1 && cyc < lim);
	endtask
	task automatic do_reset(input logic sp);
		@(posedge pclk);
		presetn <= 1'b0;
		special_mode <= sp;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		wait_vv(40);
	endtask
	// Pull the pin low until the vector shows, then wait for reset to settle
	task automatic ext_rst(input logic [15:0] exp);
		int n;
		@(posedge pclk);
		ext_low <= 1'b1;
		wait_vv(40);
		cmp_val("pin vector", exp, reset_vector);
		ext_low <= 1'b0;
		n = 0;
		while (n < 3) begin
			@(posedge pclk);
			n = sys_reset === 1'b0 ? n + 1 : 0;
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		int n, m;
		void'($urandom(73252));
		do_reset(1'b0);
		rc(16'h1039, 8'h10);
		rc(16'h103f, 8'hff);
		rc(16'h103a, 8'h00);
		i_wcm_cpu_model.xfer(1'b0, 16'h1000, 8'h00, q, e);
		cmp_val("bus error", 16'h1, {15'h0, e});
		for (int sp = 0; sp < 2; sp++) begin
			do_reset(sp[0]);
			wr(16'h1039, 8'h0b);
			wr(16'h1039, 8'h14);
			m = opt_next('h0b, 'h14, !sp);
			rc(16'h1039, m[7:0]);
			repeat (70) @(posedge pclk);
			wr(16'h1039, 8'h3b);
			m = opt_next(m, 'h3b, !sp);
			rc(16'h1039, m[7:0]);
		end
		$display("test options done");
		for (int r = 0; r < 4; r++) begin
			do_reset(1'b0);
			wr(16'h103f, 8'hf1);
			rc(16'h103f, 8'hfb);
			n = vcnt;
			repeat (40) @(posedge pclk);
			cmp_val("early reset", 16'(n), 16'(vcnt));
			ext_rst(16'hfffe);
			wr(16'h1039, {6'h04, r[1:0]});
			wait_vv(2000);
			cmp_cnt("timeout", 1 << (4 + 2 * r), 10, cyc);
			cmp_val("wd vector", 16'hfffa, reset_vector);
		end
		wr(16'h1039, 8'h11);
		n = vcnt;
		repeat (5) begin
			i_wcm_cpu_model.service();
			repeat ($urandom_range(30, 20)) @(posedge pclk);
		end
		cmp_val("serviced", 16'(n), 16'(vcnt));
		wr(16'h103a, 8'haa);
		wait_vv(100);
		cmp_val("unarmed", 16'hfffa, reset_vector);
		do_reset(1'b1);
		wr(16'h103f, 8'hfb);
		ext_rst(16'hbffe);
		n = vcnt;
		repeat (100) @(posedge pclk);
		cmp_val("inhibited", 16'(n), 16'(vcnt));
		wr(16'h103e, 8'h00);
		wait_vv(60);
		cmp_val("wd vector", 16'hbffa, reset_vector);
		$display("test watchdog done");
		do_reset(1'b0);
		foreach (mv[i]) begin
			wr(16'h1039, mv[i]);
			pclk_en <= 1'b0;
			repeat (1600) @(posedge pclk);
			cmp_val("clock fail", {15'h0, mv[i] != 8'h10}, {15'h0, clock_fail});
			pclk_en <= 1'b1;
			if (mv[i] != 8'h10) begin
				wait_vv(40);
				cmp_val("mon vector", 16'hfffc, reset_vector);
				n = 0;
				while (n < 6) begin
					@(posedge pclk);
					n = (sys_reset === 1'b0 && clock_fail === 1'b0) ? n + 1 : 0;
				end
			end
		end
		$display("test monitor done");
		for (int d = 0; d < 2; d++) begin
			do_reset(1'b0);
			wr(16'h1039, {3'h0, d[0], 4'h0});
			stop_mode <= 1'b1;
			repeat (10) @(posedge pclk);
			stop_mode <= 1'b0;
			cyc = 0;
			do begin
				@(posedge pclk);
				cyc++;
			end while (cpu_run !== 1'b1 && cyc < 5000);
			cmp_cnt("wake", d ? 4000 : 4, 3, cyc);
		end
		do_reset(1'b0);
		irq_pin_n <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp_val("irq level", 16'h1, {15'h0, irq_request});
		irq_pin_n <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp_val("irq level off", 16'h0, {15'h0, irq_request});
		wr(16'h1039, 8'h30);
		irq_pin_n <= 1'b0;
		@(posedge pclk);
		irq_pin_n <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp_val("irq edge", 16'h1, {15'h0, irq_request});
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp_val("irq ack", 16'h0, {15'h0, irq_request});
		$display("test stop and irq done");
		report_and_stop();
	end
	// Hang guard
	initial begin
		#1000000;
		failures++;
		report_and_stop();
	end
endmodule
